// File: bench/fbsi_master.sv
// Purpose: Fieldbus master stand-in
// Assumes: Shares the device clock
// Notes:   Refresh every fourth cycle while go is high
`timescale 1ns/1ns
module fbsi_master (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic go,
   input wire logic trouble_a,
   input wire logic trouble_b,
   output logic refresh_ok,
   output logic servo_on_request
);
   logic [1:0] slot_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         slot_q <= 2'h0;
         refresh_ok <= 1'h0;
         servo_on_request <= 1'h0;
      end else begin
         slot_q <= slot_q + 2'h1;
         refresh_ok <= go && slot_q == 2'h0;
         // Either flag alone is enough to stop the axis
         servo_on_request <= !(trouble_a || trouble_b);
      end
   end
endmodule : fbsi_master

// File: bench/fbsi_properties.sv
// Purpose: Port-level checks for fbsi_top
// Assumes: One clock, RESET_N async low
// Notes:   Bound to every fbsi_top instance
`timescale 1ns/1ns
module fbsi_properties import fbsi_pkg::*; #(
   parameter int unsigned RUN_TIMEOUT = RUN_TIMEOUT_CYC
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic REFRESH_OK,
   input wire logic FRAME_FOR_US,
   input wire logic CRC_ERR,
   input wire logic ALARM_CAUSE,
   input wire logic [7:0] ALARM_CODE,
   input wire logic CPU_FAULT,
   input wire logic WATCHDOG_TIMER_EXPIRED,
   input wire logic RUN_INDICATOR,
   input wire logic SERVO_ALARM_INDICATOR,
   input wire logic UNIT_FAULT_INDICATOR,
   input wire logic TROUBLE_FLAG_A,
   input wire logic TROUBLE_FLAG_B,
   input wire logic RESPONSE_SUPPRESS,
   input wire logic [7:0] DISPLAY_CODE,
   input wire logic DISPLAY_VALID
);
   // ----------------------------------------
   // Cycles since the last good refresh
   // ----------------------------------------
   logic [31:0] idle_q;
   logic wdt_seen_q;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         idle_q <= 32'h0;
      end else if (REFRESH_OK) begin
         idle_q <= 32'h0;
      end else begin
         idle_q <= idle_q + 32'h1;
      end
   end
   // A watchdog hit keeps the fault lamp on whatever the processor does
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wdt_seen_q <= 1'h0;
      end else if (WATCHDOG_TIMER_EXPIRED) begin
         wdt_seen_q <= 1'h1;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   AST_TROUBLE_PAIR: assert property (TROUBLE_FLAG_A == TROUBLE_FLAG_B)
      else $error("trouble flags differ");
   AST_ALARM_RAISE: assert property ($rose(ALARM_CAUSE) |=> TROUBLE_FLAG_A)
      else $error("no trouble after alarm");
   AST_ALARM_LED: assert property (SERVO_ALARM_INDICATOR == TROUBLE_FLAG_A)
      else $error("alarm lamp disagrees");
   AST_ALARM_HOLD: assert property (ALARM_CAUSE && TROUBLE_FLAG_A |=> TROUBLE_FLAG_A)
      else $error("alarm cleared with cause");
   AST_ALARM_CODE: assert property ($rose(ALARM_CAUSE) && !TROUBLE_FLAG_A |=>
      DISPLAY_VALID && DISPLAY_CODE == $past(ALARM_CODE)) else $error("wrong code");
   AST_FAULT_ON: assert property (CPU_FAULT |=> UNIT_FAULT_INDICATOR)
      else $error("fault lamp off");
   AST_FAULT_OFF: assert property ($fell(CPU_FAULT) && !wdt_seen_q &&
      !WATCHDOG_TIMER_EXPIRED |=> !UNIT_FAULT_INDICATOR) else $error("fault lamp stuck");
   AST_SUPPRESS: assert property (CRC_ERR && FRAME_FOR_US |=> RESPONSE_SUPPRESS)
      else $error("reply not suppressed");
   AST_SUPPRESS_CAUSE: assert property (RESPONSE_SUPPRESS |-> $past(CRC_ERR))
      else $error("suppress without error");
   AST_RUN_TIMEOUT: assert property (idle_q > RUN_TIMEOUT + 2 |-> !RUN_INDICATOR)
      else $error("run lamp past timeout");
   cover property ($rose(TROUBLE_FLAG_A));
   cover property ($fell(TROUBLE_FLAG_A));
   cover property (RESPONSE_SUPPRESS);
endmodule : fbsi_properties

bind fbsi_top fbsi_properties #(.RUN_TIMEOUT(RUN_TIMEOUT)) fbsi_properties_i (
   .CLK(CLK), .RESET_N(RESET_N), .REFRESH_OK(REFRESH_OK), .FRAME_FOR_US(FRAME_FOR_US),
   .CRC_ERR(CRC_ERR), .ALARM_CAUSE(ALARM_CAUSE), .ALARM_CODE(ALARM_CODE),
   .CPU_FAULT(CPU_FAULT), .WATCHDOG_TIMER_EXPIRED(WATCHDOG_TIMER_EXPIRED),
   .RUN_INDICATOR(RUN_INDICATOR),
   .SERVO_ALARM_INDICATOR(SERVO_ALARM_INDICATOR), .UNIT_FAULT_INDICATOR(UNIT_FAULT_INDICATOR),
   .TROUBLE_FLAG_A(TROUBLE_FLAG_A), .TROUBLE_FLAG_B(TROUBLE_FLAG_B),
   .RESPONSE_SUPPRESS(RESPONSE_SUPPRESS), .DISPLAY_CODE(DISPLAY_CODE),
   .DISPLAY_VALID(DISPLAY_VALID));

// File: bench/fbsi_top_tb_top.sv
// Purpose: Self-checking bench for fbsi_top
// Assumes: Short counts via parameters
// Notes:   Outputs read at the edge, before it updates them
`timescale 1ns/1ns
module fbsi_top_tb_top import fbsi_pkg::*;;
   localparam int RT = 20;
   localparam int CF = 50;
   logic CLK = 1'h0, RESET_N = 1'h0, TX_BIT = 1'h1, CARRIER = 1'h0, FRAME_FOR_US = 1'h0;
   logic CRC_ERR = 1'h0, ABORT_ERR = 1'h0, ALARM_CAUSE = 1'h0, WARN_CAUSE = 1'h0;
   logic CPU_FAULT = 1'h0, PANEL_SET = 1'h0, WATCHDOG_TIMER_EXPIRED = 1'h0;
   logic ALARM_RESET_REQ = 1'h0, WR_STB = 1'h0, RD_STB = 1'h0, go = 1'h0;
   logic [2:0] BAUD_SETTING = 3'h0;
   logic [6:0] STATION_SETTING = 7'h01;
   logic [7:0] ALARM_CODE = 8'h00, WARN_CODE = 8'h00, ADDR = 8'h00;
   logic [1:0] ALARM_METHODS = 2'h0;
   logic [31:0] WR_DATA = 32'h0, RD_DATA, d;
   logic REFRESH_OK, RUN, SEND, RECV, LERR, SALM, UFLT, TRA, TRB, SUP, DV, son;
   logic [7:0] DC;
   int errors = 0, checks = 0, cyc_n = 0, n;
   wire [3:0] pat = {RUN, SEND, RECV, LERR};
   fbsi_top #(.RUN_TIMEOUT(RT), .CHANGE_FLASH(CF), .FLASH_HALF(3)) fbsi_top_i (
      .CLK(CLK), .RESET_N(RESET_N), .REFRESH_OK(REFRESH_OK), .TX_BIT(TX_BIT),
      .CARRIER(CARRIER), .FRAME_FOR_US(FRAME_FOR_US), .CRC_ERR(CRC_ERR),
      .ABORT_ERR(ABORT_ERR), .BAUD_SETTING(BAUD_SETTING), .STATION_SETTING(STATION_SETTING),
      .ALARM_CAUSE(ALARM_CAUSE), .ALARM_CODE(ALARM_CODE), .ALARM_METHODS(ALARM_METHODS),
      .WARN_CAUSE(WARN_CAUSE), .WARN_CODE(WARN_CODE), .CPU_FAULT(CPU_FAULT),
      .WATCHDOG_TIMER_EXPIRED(WATCHDOG_TIMER_EXPIRED), .PANEL_SET(PANEL_SET),
      .ALARM_RESET_REQ(ALARM_RESET_REQ), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB),
      .RD_STB(RD_STB), .RD_DATA(RD_DATA), .RUN_INDICATOR(RUN), .SEND_INDICATOR(SEND),
      .RECV_INDICATOR(RECV), .LINK_ERR_INDICATOR(LERR), .SERVO_ALARM_INDICATOR(SALM),
      .UNIT_FAULT_INDICATOR(UFLT), .TROUBLE_FLAG_A(TRA), .TROUBLE_FLAG_B(TRB),
      .RESPONSE_SUPPRESS(SUP), .DISPLAY_CODE(DC), .DISPLAY_VALID(DV));
   fbsi_master fbsi_master_i (.clk(CLK), .reset_n(RESET_N), .go(go), .trouble_a(TRA),
      .trouble_b(TRB), .refresh_ok(REFRESH_OK), .servo_on_request(son));
   always #5 CLK = ~CLK;
   // Whole run needs under 700 cycles
   always @(posedge CLK) begin
      cyc_n++;
      if (cyc_n == 3000) begin
         errors++;
         results();
      end
   end
   task cyc(input int k);
      repeat (k) @(posedge CLK);
   endtask : cyc
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         errors++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [7:0] a);
      ADDR <= a; WR_DATA <= 32'h1; WR_STB <= 1'h1; cyc(1); WR_STB <= 1'h0; cyc(1);
   endtask : wr
   task rd(input logic [7:0] a);
      ADDR <= a; RD_STB <= 1'h1; cyc(1); RD_STB <= 1'h0; cyc(1); d = RD_DATA;
   endtask : rd
   task refresh;
      go <= 1'h1; cyc(10); go <= 1'h0; cyc(2);
   endtask : refresh
   task t_link;
      rd(REG_STATUS); chk(d, 0); rd(8'h0c); chk(d, 0);
      wr(REG_CODE); rd(REG_CODE); chk(d, 0);
      refresh(); chk(RUN, 1);
      cyc(RT - 10); chk(RUN, 1);
      cyc(14); chk(RUN, 0);
      TX_BIT <= 1'h0; CARRIER <= 1'h1; cyc(2); chk(pat[2:1], 2'h3);
      TX_BIT <= 1'h1; CARRIER <= 1'h0; cyc(2); chk(pat[2:1], 2'h0);
      FRAME_FOR_US <= 1'h1; CRC_ERR <= 1'h1; cyc(1); CRC_ERR <= 1'h0; cyc(1);
      chk({SUP, LERR}, 2'h3);
      cyc(1); chk(SUP, 0);
      refresh(); chk(LERR, 0);
      ABORT_ERR <= 1'h1; cyc(1); ABORT_ERR <= 1'h0; cyc(1); chk({SUP, LERR}, 2'h1);
      FRAME_FOR_US <= 1'h0; refresh(); chk(LERR, 0);
      CRC_ERR <= 1'h1; cyc(1); CRC_ERR <= 1'h0; cyc(1); chk({SUP, LERR}, 2'h0);
   endtask : t_link
   task t_alarm;
      ALARM_CODE <= 8'h32; ALARM_METHODS <= 2'h2; ALARM_CAUSE <= 1'h1; cyc(2);
      chk({TRA, TRB, SALM}, 3'h7);
      chk({DV, DC}, 9'h132);
      cyc(1); chk(son, 0);
      wr(REG_CONTROL); chk(TRA, 1);
      ALARM_CAUSE <= 1'h0; PANEL_SET <= 1'h1; cyc(1); PANEL_SET <= 1'h0; cyc(1);
      chk(TRA, 1);
      ALARM_RESET_REQ <= 1'h1; cyc(1); ALARM_RESET_REQ <= 1'h0; cyc(1);
      chk({TRA, SALM, DV}, 3'h0);
      ALARM_METHODS <= 2'h1; ALARM_CAUSE <= 1'h1; cyc(1); ALARM_CAUSE <= 1'h0; cyc(1);
      wr(REG_CONTROL); chk(TRA, 1);
      PANEL_SET <= 1'h1; cyc(1); PANEL_SET <= 1'h0; cyc(1); chk(TRA, 0);
      WARN_CODE <= 8'h9f; WARN_CAUSE <= 1'h1; CPU_FAULT <= 1'h1; cyc(2);
      chk({DV, DC, TRA, UFLT}, 11'h67d);
      rd(REG_CODE); chk(d, 32'h19f);
      WARN_CAUSE <= 1'h0; CPU_FAULT <= 1'h0; cyc(2); chk({DV, UFLT}, 2'h0);
   endtask : t_alarm
   task t_flash;
      n = 0;
      cyc(2);
      repeat (12) begin
         cyc(1);
         n += LERR;
      end
      chk(n > 0 && n < 12, 1);
      chk(pat[3:1], 0);
      cyc(CF); chk(pat, 0);
   endtask : t_flash
   task t_setting;
      BAUD_SETTING <= 3'h5; cyc(2); chk(pat, 4'h5);
      rd(REG_STATUS); chk(d[11:9], 3'h3);
      BAUD_SETTING <= 3'h4; t_flash();
      STATION_SETTING <= 7'h00; cyc(2); chk(pat, 4'h3);
      STATION_SETTING <= 7'h41; cyc(2); chk(pat, 4'h3);
      STATION_SETTING <= 7'h40; t_flash();
      WATCHDOG_TIMER_EXPIRED <= 1'h1; cyc(1); WATCHDOG_TIMER_EXPIRED <= 1'h0;
      cyc(1); chk(pat, 4'h6);
      cyc(20); chk(pat, 4'h6);
   endtask : t_setting
   task results;
      if (errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results
   initial begin
      cyc(3);
      chk({pat, SALM, UFLT, TRA, SUP, DV}, 0);
      cyc(1);
      RESET_N <= 1'h1;
      cyc(2);
      t_link();
      t_alarm();
      t_setting();
      results();
   end
endmodule : fbsi_top_tb_top

// File: rtl/fbsi_pkg.sv
// Purpose: Shared constants and types for the fieldbus status indicator block.
// Assumes: One 100 MHz clock; register port with 32-bit data.
// Notes:   Counts above 4096 cycles are defaults for top-level parameters.
package fbsi_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned RUN_TIMEOUT_MS = 100;
   localparam int unsigned CHANGE_FLASH_MS = 4000;
   localparam int unsigned FLASH_HALF_MS = 250;
   localparam int unsigned RUN_TIMEOUT_CYC = RUN_TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int unsigned CHANGE_FLASH_CYC = CHANGE_FLASH_MS * 1000 * CLK_MHZ;
   localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * 1000 * CLK_MHZ;
   localparam int unsigned CNT_W = 32;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CONTROL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CODE = 8'h08;
   localparam int unsigned CTRL_ALARM_RESET = 0;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Settings legality
   // ----------------------------------------------------------------
   localparam logic [2:0] BAUD_MAX = 3'h4;
   localparam logic [6:0] STATION_MIN = 7'h01;
   localparam logic [6:0] STATION_MAX = 7'h40;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic run;
      logic send;
      logic recv;
      logic link_err;
      logic servo_alarm;
      logic unit_fault;
   } fbsi_leds_t;

   localparam fbsi_leds_t LEDS_OFF = '{default: 1'b0};

   typedef enum logic [1:0] {
      FBSI_NORMAL,
      FBSI_ALARM
   } fbsi_alarm_st_t;

   typedef struct packed {
      logic [CNT_W-1:0] run_cnt;
      logic [CNT_W-1:0] chg_cnt;
      logic flash_phase;
      logic link_err;
      logic wdt_hit;
      logic [2:0] base_baud;
      logic [6:0] base_station;
      logic base_valid;
      fbsi_alarm_st_t alarm_st;
      logic [7:0] alarm_code;
      logic [1:0] alarm_methods;
      fbsi_leds_t leds;
      logic trouble;
      logic suppress;
      logic [7:0] disp_code;
      logic disp_valid;
      logic [31:0] rd_data;
   } fbsi_state_t;

endpackage : fbsi_pkg

// File: rtl/fbsi_tick.sv
// Purpose: Divider that gives a one-cycle enable pulse every DIV clocks.
// Assumes: Single clock domain.
// Notes:   Used as the flash rate prescaler.
`timescale 1ns/1ns
module fbsi_tick import fbsi_pkg::*; #(
   parameter int unsigned DIV = FLASH_HALF_CYC
) (
   input wire logic CLK,
   input wire logic RESET_N,
   output logic TICK
);

   if (DIV < 1) begin : g_chk
      $error("fbsi_tick: DIV must be at least 1");
   end

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic tick;
   } fbsi_tick_st_t;

   fbsi_tick_st_t s_q;
   fbsi_tick_st_t s_d;

   always_comb begin
      s_d = s_q;
      if (s_q.cnt == CNT_W'(DIV - 1)) begin
         s_d.cnt = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 1'b1;
         s_d.tick = 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign TICK = s_q.tick;

endmodule : fbsi_tick

// File: rtl/fbsi_top.sv
// Purpose: Status indicators, trouble flags and alarm latch of a fieldbus unit.
// Assumes: All inputs synchronous to CLK; event inputs are one-cycle pulses.
// Notes:   Registers: CONTROL (write), STATUS and CODE (read).
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns

// Operation
// - Run indicator on at good refresh
// - Run indicator off after refresh timeout
// - Send indicator on while sent bit 0
// - Receive indicator on while carrier present
// - Link error on CRC or abort
// - Servo alarm indicator follows alarm state
// - Unit fault indicator follows processor fault
// - Suppress response on CRC error frame
// - Illegal baud and station show patterns
// - Setting change flashes error about 4s
// - Watchdog expiry shows hardware fault pattern
// - Display active alarm or warning code
// - Alarm asserts both trouble flags
// - Alarm clears only after cause, permitted method
// - Warnings clear automatically with cause
module fbsi_top import fbsi_pkg::*; #(
   parameter int unsigned RUN_TIMEOUT = RUN_TIMEOUT_CYC,
   parameter int unsigned CHANGE_FLASH = CHANGE_FLASH_CYC,
   parameter int unsigned FLASH_HALF = FLASH_HALF_CYC
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic REFRESH_OK,
   input wire logic TX_BIT,
   input wire logic CARRIER,
   input wire logic FRAME_FOR_US,
   input wire logic CRC_ERR,
   input wire logic ABORT_ERR,
   input wire logic [2:0] BAUD_SETTING,
   input wire logic [6:0] STATION_SETTING,
   input wire logic ALARM_CAUSE,
   input wire logic [7:0] ALARM_CODE,
   input wire logic [1:0] ALARM_METHODS,
   input wire logic WARN_CAUSE,
   input wire logic [7:0] WARN_CODE,
   input wire logic CPU_FAULT,
   input wire logic WATCHDOG_TIMER_EXPIRED,
   input wire logic PANEL_SET,
   input wire logic ALARM_RESET_REQ,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WR_DATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [31:0] RD_DATA,
   output logic RUN_INDICATOR,
   output logic SEND_INDICATOR,
   output logic RECV_INDICATOR,
   output logic LINK_ERR_INDICATOR,
   output logic SERVO_ALARM_INDICATOR,
   output logic UNIT_FAULT_INDICATOR,
   output logic TROUBLE_FLAG_A,
   output logic TROUBLE_FLAG_B,
   output logic RESPONSE_SUPPRESS,
   output logic [7:0] DISPLAY_CODE,
   output logic DISPLAY_VALID
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (RUN_TIMEOUT < 1 || CHANGE_FLASH < 1) begin : g_chk
      $error("fbsi_top: timeouts must be at least one cycle");
   end
   // The divider cannot pulse more often than every clock
   if (FLASH_HALF < 1) begin : g_chk_flash
      $error("fbsi_top: FLASH_HALF must be at least one cycle");
   end

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   // CONTROL (write): bit 0 asks for an alarm clear; it only takes effect
   //    once the cause is gone and the alarm allows a software clear.
   // STATUS (read):
   //    [5:0]  lamps: run, send, receive, link error, servo alarm, unit fault
   //    [6]    trouble flag
   //    [7]    watchdog fault held
   //    [8]    warning present
   //    [9]    setting-change flash running
   //    [10]   baud setting illegal
   //    [11]   station setting illegal
   // CODE (read): [7:0] displayed code, [8] code valid.
   // Read data stands one cycle after the strobe and is zero otherwise, so a
   // late sample reads zero rather than a stale word.

   // ----------------------------------------------------------------
   // Flash prescaler
   // ----------------------------------------------------------------
   logic flash_tick;

   fbsi_tick #(
      .DIV(FLASH_HALF)
   ) fbsi_tick_i (
      .CLK(CLK),
      .RESET_N(RESET_N),
      .TICK(flash_tick)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   fbsi_state_t s_q;
   fbsi_state_t s_d;

   logic baud_bad;
   logic station_bad;
   logic changed;
   logic sw_reset;
   logic clear_ok;
   logic frame_bad;

   always_comb begin
      s_d = s_q;
      baud_bad = BAUD_SETTING > BAUD_MAX;
      station_bad = STATION_SETTING < STATION_MIN || STATION_SETTING > STATION_MAX;
      changed = s_q.base_valid &&
                (BAUD_SETTING != s_q.base_baud || STATION_SETTING != s_q.base_station);
      sw_reset = WR_STB && ADDR == REG_CONTROL && WR_DATA[CTRL_ALARM_RESET];
      frame_bad = FRAME_FOR_US && (CRC_ERR || ABORT_ERR);

      // ----------------------------------------------------------------
      // Link supervision
      // ----------------------------------------------------------------
      // Refresh timer restarts on every good frame
      if (REFRESH_OK) begin
         s_d.run_cnt = CNT_W'(RUN_TIMEOUT);
      end else if (s_q.run_cnt != '0) begin
         s_d.run_cnt = s_q.run_cnt - 1'b1;
      end

      // Error latch: a good refresh clears it, a new error in the same cycle wins
      if (frame_bad) begin
         s_d.link_err = 1'b1;
      end else if (REFRESH_OK) begin
         s_d.link_err = 1'b0;
      end

      // Only CRC errors block the reply; aborts are flagged but still answered
      s_d.suppress = FRAME_FOR_US && CRC_ERR;

      // ----------------------------------------------------------------
      // Settings watch
      // ----------------------------------------------------------------
      // Settings captured once after reset, then watched for changes
      if (!s_q.base_valid) begin
         s_d.base_valid = 1'b1;
         s_d.base_baud = BAUD_SETTING;
         s_d.base_station = STATION_SETTING;
      end else if (changed) begin
         s_d.base_baud = BAUD_SETTING;
         s_d.base_station = STATION_SETTING;
         s_d.chg_cnt = CNT_W'(CHANGE_FLASH);
      end else if (s_q.chg_cnt != '0) begin
         s_d.chg_cnt = s_q.chg_cnt - 1'b1;
      end

      if (flash_tick) begin
         s_d.flash_phase = !s_q.flash_phase;
      end

      // ----------------------------------------------------------------
      // Fault and alarm latches
      // ----------------------------------------------------------------
      // Watchdog fault holds until reset
      if (WATCHDOG_TIMER_EXPIRED) begin
         s_d.wdt_hit = 1'b1;
      end

      // Alarm latch; a still-present cause always beats a clear request
      clear_ok = !ALARM_CAUSE &&
                 ((PANEL_SET && s_q.alarm_methods[0]) ||
                  ((ALARM_RESET_REQ || sw_reset) && s_q.alarm_methods[1]));
      case (s_q.alarm_st)
         FBSI_NORMAL: begin
            if (ALARM_CAUSE) begin
               s_d.alarm_st = FBSI_ALARM;
               s_d.alarm_code = ALARM_CODE;
               s_d.alarm_methods = ALARM_METHODS;
            end
         end
         FBSI_ALARM: begin
            if (clear_ok) begin
               s_d.alarm_st = FBSI_NORMAL;
            end
         end
         default: begin
            s_d.alarm_st = FBSI_NORMAL;
         end
      endcase

      s_d.trouble = s_d.alarm_st == FBSI_ALARM;

      // ----------------------------------------------------------------
      // Code display and lamps
      // ----------------------------------------------------------------
      // Code display: alarm first, warning only while its cause lasts
      if (s_d.alarm_st == FBSI_ALARM) begin
         s_d.disp_code = s_d.alarm_code;
         s_d.disp_valid = 1'b1;
      end else if (WARN_CAUSE) begin
         s_d.disp_code = WARN_CODE;
         s_d.disp_valid = 1'b1;
      end else begin
         s_d.disp_code = '0;
         s_d.disp_valid = 1'b0;
      end

      // Indicators: plain link view first, fault patterns override it
      // Lamp patterns (run, send, receive, error), highest priority first:
      //    watchdog fault    off, on,  on,  off
      //    baud illegal      off, on,  off, on
      //    station illegal   off, off, on,  on
      //    setting changed   off, off, off, flashing
      // The watchdog outranks the settings: a stalled processor cannot judge them.
      s_d.leds.run = s_d.run_cnt != '0;
      s_d.leds.send = !TX_BIT;
      s_d.leds.recv = CARRIER;
      s_d.leds.link_err = s_d.link_err;
      if (s_d.wdt_hit) begin
         s_d.leds.run = 1'b0;
         s_d.leds.send = 1'b1;
         s_d.leds.recv = 1'b1;
         s_d.leds.link_err = 1'b0;
      end else if (baud_bad) begin
         s_d.leds.run = 1'b0;
         s_d.leds.send = 1'b1;
         s_d.leds.recv = 1'b0;
         s_d.leds.link_err = 1'b1;
      end else if (station_bad) begin
         s_d.leds.run = 1'b0;
         s_d.leds.send = 1'b0;
         s_d.leds.recv = 1'b1;
         s_d.leds.link_err = 1'b1;
      end else if (s_d.chg_cnt != '0) begin
         s_d.leds.run = 1'b0;
         s_d.leds.send = 1'b0;
         s_d.leds.recv = 1'b0;
         s_d.leds.link_err = s_d.flash_phase;
      end
      s_d.leds.servo_alarm = s_d.alarm_st == FBSI_ALARM;
      s_d.leds.unit_fault = CPU_FAULT || s_d.wdt_hit;

      // ----------------------------------------------------------------
      // Register reads
      // ----------------------------------------------------------------
      // Register reads: data in the cycle after the strobe only
      s_d.rd_data = RD_ZERO;
      if (RD_STB) begin
         case (ADDR)
            REG_STATUS: begin
               s_d.rd_data = {20'h0,
                              station_bad,
                              baud_bad,
                              s_q.chg_cnt != '0,
                              WARN_CAUSE,
                              s_q.wdt_hit,
                              s_q.trouble,
                              s_q.leds};
            end
            REG_CODE: begin
               s_d.rd_data = {23'h0, s_q.disp_valid, s_q.disp_code};
            end
            default: begin
               s_d.rd_data = RD_ZERO;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign RD_DATA = s_q.rd_data;
   assign RUN_INDICATOR = s_q.leds.run;
   assign SEND_INDICATOR = s_q.leds.send;
   assign RECV_INDICATOR = s_q.leds.recv;
   assign LINK_ERR_INDICATOR = s_q.leds.link_err;
   assign SERVO_ALARM_INDICATOR = s_q.leds.servo_alarm;
   assign UNIT_FAULT_INDICATOR = s_q.leds.unit_fault;
   // Both flags carry the same trouble state; the master watches either one
   assign TROUBLE_FLAG_A = s_q.trouble;
   assign TROUBLE_FLAG_B = s_q.trouble;
   assign RESPONSE_SUPPRESS = s_q.suppress;
   assign DISPLAY_CODE = s_q.disp_code;
   assign DISPLAY_VALID = s_q.disp_valid;

endmodule : fbsi_top
